// ---- core/tcs_pkg.sv ----
// shared widths, codes and carriers of the trigger command select block
package tcs_pkg;

	localparam int TCS_TRG_CMD_W  = 4;
	localparam int TCS_DAQ_CMD_W  = 4;
	localparam int TCS_TOKEN_W    = 12;
	localparam int TCS_WORD_W     = 16;
	localparam int TCS_NUM_DET    = 8;
	localparam int TCS_CTRL_W     = 3;
	localparam int TCS_FIFO_DEPTH = 16;

	localparam int TCS_SEL_LO  = 0;
	localparam int TCS_SEL_HI  = 1;
	localparam int TCS_SEL_RSV = 2;

	// trigger command code that means no command in this slot
	localparam logic [TCS_TRG_CMD_W-1:0] TCS_CMD_NONE = 4'h0;

	typedef enum logic [1:0] {
		TCS_SRC_FIFO_A = 2'b00,
		TCS_SRC_FIFO_B = 2'b01,
		TCS_SRC_PREV   = 2'b10,
		TCS_SRC_ZERO   = 2'b11
	} tcs_src_t;

	typedef enum logic [0:0] {
		TCS_ST_IDLE      = 1'b0,
		TCS_ST_WAIT_MEZZ = 1'b1
	} tcs_state_t;

	// one trigger command slot as it travels through the board
	typedef struct packed {
		logic [TCS_DAQ_CMD_W-1:0] daq_cmd;
		logic [TCS_TOKEN_W-1:0]   token;
		logic [TCS_TRG_CMD_W-1:0] trg_cmd;
	} tcs_cmd_t;

	localparam tcs_cmd_t TCS_CMD_ZERO = '0;

	// backplane side fields that go to the mezzanine untouched
	typedef struct packed {
		logic [TCS_WORD_W-1:0]  trigger_word_bits;
		logic [TCS_NUM_DET-1:0] det_select;
	} tcs_side_t;

endpackage

// ---- core/tcs_trigger_command_select.sv ----
// trigger command merge between backplane, mezzanine and sequencer
// Notes on behaviour
// - DAQ command and token bypass the mezzanine
// - trigger command goes out to mezzanine, returns
// - commands during pulser sequence are queued, dropped only when the queue is full
// - mezzanine select picks DAQ and token sources, command always from mezzanine
// - select 0: mezzanine command, DAQ/token from FIFO
// - select 1: same sources as select 0
// - select 2: reuse previous valid DAQ/token
// - select 3: DAQ command and token forced zero
// - backplane inputs captured on bunch strobe rise
// - per-detector busy, active low, open collector
`timescale 1ns/100ps
`default_nettype none

module tcs_trigger_command_select
	import tcs_pkg::*;
#(
	parameter int FIFO_DEPTH = TCS_FIFO_DEPTH,
	parameter int OWN_DET    = 0
) (
	input  wire logic                     CLK_SYS,              // 50 MHz
	input  wire logic                     RESET_N,              // async reset
	input  wire logic                     BUNCH_STROBE,         // slot strobe
	input  wire logic                     BUNCH_STROBE_DELAYED, // mezz strobe
	input  wire logic [TCS_TRG_CMD_W-1:0] TRG_CMD,              // backplane
	input  wire logic [TCS_DAQ_CMD_W-1:0] DAQ_CMD,              // backplane
	input  wire logic [TCS_TOKEN_W-1:0]   TRG_TOKEN,            // backplane
	input  wire logic [TCS_WORD_W-1:0]    TRG_WORD,             // backplane
	input  wire logic [TCS_NUM_DET-1:0]   DET_SELECT,           // backplane
	input  wire logic [TCS_TRG_CMD_W-1:0] CMD_FROM_MEZZANINE,   // mezz cmd
	input  wire logic [TCS_CTRL_W-1:0]    MEZZ_CONTROL,         // source sel
	input  wire logic                     MEZZ_BUSY,            // dead time
	output logic [TCS_TRG_CMD_W-1:0]      CMD_TO_MEZZANINE,     // to mezz
	output logic [TCS_WORD_W-1:0]         TRIGGER_WORD_BITS,    // to mezz
	output logic [TCS_NUM_DET-1:0]        DET_SELECT_OUT,       // to mezz
	output logic [TCS_TRG_CMD_W-1:0]      SEQ_TRG_CMD,          // sequencer
	output logic [TCS_DAQ_CMD_W-1:0]      SEQ_DAQ_CMD,          // sequencer
	output logic [TCS_TOKEN_W-1:0]        SEQ_TOKEN,            // sequencer
	output logic                          SEQ_VALID,            // slot pulse
	output logic [TCS_NUM_DET-1:0]        BUSY_N_O,             // always low
	output logic [TCS_NUM_DET-1:0]        BUSY_N_OE             // pull low
);

	localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
	localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(FIFO_DEPTH);
	localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(FIFO_DEPTH - 1);

	logic       stb_reg;
	logic       dstb_reg;
	logic       stb_edge;
	logic       dstb_edge;
	logic       cap_valid_reg;
	tcs_cmd_t   live_reg;
	tcs_side_t  side_reg;
	tcs_cmd_t   cur_reg;
	tcs_cmd_t   last_reg;
	tcs_state_t state_reg;
	tcs_cmd_t   mem_reg [FIFO_DEPTH];
	logic [PTR_W-1:0] wr_ptr_reg;
	logic [PTR_W-1:0] rd_ptr_reg;
	logic [CNT_W-1:0] count_reg;
	logic       live_valid;
	logic       fifo_full;
	logic       fifo_empty;
	logic       push;
	logic       pop;
	logic       emit;
	tcs_src_t   src;
	tcs_cmd_t   slot_next;

	// inputs are synchronous, so a one-flop history is enough for edges
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			stb_reg  <= 1'b0;
			dstb_reg <= 1'b0;
		end else begin
			stb_reg  <= BUNCH_STROBE;
			dstb_reg <= BUNCH_STROBE_DELAYED;
		end
	end

	assign stb_edge  = BUNCH_STROBE & ~stb_reg;
	assign dstb_edge = BUNCH_STROBE_DELAYED & ~dstb_reg;

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			live_reg      <= TCS_CMD_ZERO;
			side_reg      <= '0;
			cap_valid_reg <= 1'b0;
		end else begin
			cap_valid_reg <= stb_edge;
			if (stb_edge) begin
				live_reg <= '{daq_cmd: DAQ_CMD, token: TRG_TOKEN,
					trg_cmd: TRG_CMD};
				side_reg <= '{trigger_word_bits: TRG_WORD,
					det_select: DET_SELECT};
			end
		end
	end

	assign live_valid = (live_reg.trg_cmd != TCS_CMD_NONE);
	assign fifo_full  = (count_reg == CNT_FULL);
	assign fifo_empty = (count_reg == '0);
	// queue while the mezzanine is busy, and behind anything still queued
	assign push = cap_valid_reg & live_valid & (MEZZ_BUSY | ~fifo_empty)
		& ~fifo_full;
	assign pop  = cap_valid_reg & ~MEZZ_BUSY & ~fifo_empty;

	always_comb begin
		if (pop) begin
			slot_next = mem_reg[rd_ptr_reg];
		end else if (MEZZ_BUSY) begin
			slot_next = TCS_CMD_ZERO;
		end else begin
			slot_next = live_reg;
		end
	end

	generate
		for (genvar i = 0; i < FIFO_DEPTH; i++) begin : g_entry
			always_ff @(posedge CLK_SYS or negedge RESET_N) begin
				if (!RESET_N) begin
					mem_reg[i] <= TCS_CMD_ZERO;
				end else if (push && wr_ptr_reg == PTR_W'(i)) begin
					mem_reg[i] <= live_reg;
				end
			end
		end
	endgenerate

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0
					: wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0
					: rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end

	// slot pairing: strobe starts a slot, delayed strobe closes it
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			state_reg <= TCS_ST_IDLE;
		end else begin
			case (state_reg)
				TCS_ST_IDLE: begin
					if (cap_valid_reg) begin
						state_reg <= TCS_ST_WAIT_MEZZ;
					end
				end
				TCS_ST_WAIT_MEZZ: begin
					if (dstb_edge) begin
						state_reg <= TCS_ST_IDLE;
					end
				end
				default: begin
					state_reg <= TCS_ST_IDLE;
				end
			endcase
		end
	end

	assign emit = (state_reg == TCS_ST_WAIT_MEZZ) & dstb_edge;
	// the top control line carries no meaning here
	assign src  = tcs_src_t'(MEZZ_CONTROL[TCS_SEL_HI:TCS_SEL_LO]);

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			cur_reg           <= TCS_CMD_ZERO;
			CMD_TO_MEZZANINE  <= TCS_CMD_NONE;
			TRIGGER_WORD_BITS <= '0;
			DET_SELECT_OUT    <= '0;
		end else if (cap_valid_reg) begin
			// DAQ command and token stay on board, never go to the mezzanine
			cur_reg           <= slot_next;
			CMD_TO_MEZZANINE  <= slot_next.trg_cmd;
			TRIGGER_WORD_BITS <= side_reg.trigger_word_bits;
			DET_SELECT_OUT    <= side_reg.det_select;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			SEQ_TRG_CMD <= TCS_CMD_NONE;
			SEQ_DAQ_CMD <= '0;
			SEQ_TOKEN   <= '0;
			SEQ_VALID   <= 1'b0;
			last_reg    <= TCS_CMD_ZERO;
		end else begin
			SEQ_VALID <= emit;
			if (emit) begin
				SEQ_TRG_CMD <= CMD_FROM_MEZZANINE;
				case (src)
					// 0 and 1 read the same; both take the queue's slot
					TCS_SRC_FIFO_A, TCS_SRC_FIFO_B: begin
						SEQ_DAQ_CMD <= cur_reg.daq_cmd;
						SEQ_TOKEN   <= cur_reg.token;
					end
					TCS_SRC_PREV: begin
						SEQ_DAQ_CMD <= last_reg.daq_cmd;
						SEQ_TOKEN   <= last_reg.token;
					end
					default: begin
						SEQ_DAQ_CMD <= '0;
						SEQ_TOKEN   <= '0;
					end
				endcase
				if (cur_reg.trg_cmd != TCS_CMD_NONE) begin
					last_reg <= cur_reg;
				end
			end
		end
	end

	// open collector: level fixed low, only the enable moves
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			BUSY_N_O  <= '0;
			BUSY_N_OE <= '0;
		end else begin
			BUSY_N_O  <= '0;
			BUSY_N_OE <= '0;
			// a full queue must also stop triggers, or commands would be lost
			BUSY_N_OE[OWN_DET] <= MEZZ_BUSY | fifo_full;
		end
	end

	chk_capture_on_edge: assert property (@(posedge CLK_SYS)
		disable iff (!RESET_N)
		stb_edge |=> live_reg.trg_cmd == $past(TRG_CMD)
			&& live_reg.token == $past(TRG_TOKEN))
		else $error("backplane not captured on strobe");
	chk_cmd_to_mezz: assert property (@(posedge CLK_SYS)
		disable iff (!RESET_N)
		cap_valid_reg && !MEZZ_BUSY && fifo_empty
			|=> CMD_TO_MEZZANINE == $past(live_reg.trg_cmd))
		else $error("live command not passed to mezzanine");
	chk_queue_busy: assert property (@(posedge CLK_SYS)
		disable iff (!RESET_N)
		cap_valid_reg && MEZZ_BUSY && live_valid && !fifo_full
			|=> count_reg == $past(count_reg) + 1'b1)
		else $error("command during busy not queued");
	chk_release_order: assert property (@(posedge CLK_SYS)
		disable iff (!RESET_N)
		pop |=> CMD_TO_MEZZANINE == $past(mem_reg[rd_ptr_reg].trg_cmd)
			&& rd_ptr_reg != $past(rd_ptr_reg))
		else $error("queue head not released");
	chk_src_fifo: assert property (@(posedge CLK_SYS)
		disable iff (!RESET_N)
		emit && !src[1] |=> SEQ_VALID && SEQ_DAQ_CMD == $past(cur_reg.daq_cmd)
			&& SEQ_TOKEN == $past(cur_reg.token))
		else $error("slot DAQ or token not sent");
	chk_src_prev: assert property (@(posedge CLK_SYS)
		disable iff (!RESET_N)
		emit && src == TCS_SRC_PREV
			|=> SEQ_TOKEN == $past(last_reg.token))
		else $error("previous token not reused");
	chk_src_zero: assert property (@(posedge CLK_SYS)
		disable iff (!RESET_N)
		emit && src == TCS_SRC_ZERO
			|=> SEQ_DAQ_CMD == '0 && SEQ_TOKEN == '0 ##1 !SEQ_VALID)
		else $error("DAQ or token not zeroed");
	chk_mezz_cmd_out: assert property (@(posedge CLK_SYS)
		disable iff (!RESET_N)
		emit |=> SEQ_TRG_CMD == $past(CMD_FROM_MEZZANINE))
		else $error("mezzanine command not sent");
	chk_busy_drive: assert property (@(posedge CLK_SYS)
		disable iff (!RESET_N)
		MEZZ_BUSY |=> BUSY_N_OE[OWN_DET] && BUSY_N_O == '0)
		else $error("busy not pulled low");

	cov_queue_drain: cover property (@(posedge CLK_SYS)
		disable iff (!RESET_N) pop && push);
	cov_src_prev: cover property (@(posedge CLK_SYS)
		disable iff (!RESET_N) emit && src == TCS_SRC_PREV);
	cov_src_zero: cover property (@(posedge CLK_SYS)
		disable iff (!RESET_N) emit && src == TCS_SRC_ZERO);
	cov_full: cover property (@(posedge CLK_SYS)
		disable iff (!RESET_N) fifo_full);

endmodule // tcs_trigger_command_select

`default_nettype wire

// ---- test/tcs_mezz_model.sv ----
// behavioural mezzanine card facing the trigger command select block
`timescale 1ns/100ps
`default_nettype none

module tcs_mezz_model
	import tcs_pkg::*;
#(
	parameter logic [TCS_TRG_CMD_W-1:0] PULSE_CMD = 4'h9 // pulser command
) (
	input  wire logic [TCS_TRG_CMD_W-1:0] cmd_in,   // from the board
	input  wire logic [1:0]               sel,      // wanted source
	input  wire logic                     rsv_high, // misdrive bit 2
	input  wire logic                     busy_req, // pulser running
	output logic [TCS_TRG_CMD_W-1:0]      cmd_out,  // back to the board
	output logic [TCS_CTRL_W-1:0]         control,  // source select
	output logic                          busy      // dead time
);
	// pulser commands replace whatever the board hands over
	assign cmd_out = busy_req ? PULSE_CMD : cmd_in;
	assign busy    = busy_req;
	// static settings only, so the configuration port is left open
	// reserved bit stays low unless a scenario asks otherwise
	assign control = {rsv_high, sel};
endmodule // tcs_mezz_model

`default_nettype wire

// ---- test/test_trigger_command_select.sv ----
// self-checking bench of the trigger command select block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
	mismatches++; $display("unexpected %s exp %h got %h", n, e, g); end end

module test_trigger_command_output_select import tcs_pkg::*;;
	logic                     clk_sys, reset_n, strobe, strobe_dly;
	logic                     rsv_high, busy_req, seq_valid, mezz_busy;
	logic [1:0]               sel;
	logic [TCS_CTRL_W-1:0]    control;
	logic [TCS_TRG_CMD_W-1:0] trg_cmd, to_mezz, from_mezz, seq_trg;
	logic [TCS_DAQ_CMD_W-1:0] daq_cmd, seq_daq;
	logic [TCS_TOKEN_W-1:0]   token, seq_tok;
	logic [TCS_WORD_W-1:0]    word, word_out;
	logic [TCS_NUM_DET-1:0]   det_sel, det_out, busy_o, busy_oe;
	int                       mismatches, checked;
	localparam int            QUEUE_DEPTH = 4;

	tcs_trigger_command_select #(.FIFO_DEPTH(QUEUE_DEPTH), .OWN_DET(0))
	tcs_trigger_command_select_inst (.CLK_SYS(clk_sys), .RESET_N(reset_n),
		.BUNCH_STROBE(strobe), .BUNCH_STROBE_DELAYED(strobe_dly),
		.TRG_CMD(trg_cmd), .DAQ_CMD(daq_cmd), .TRG_TOKEN(token),
		.TRG_WORD(word), .DET_SELECT(det_sel), .CMD_FROM_MEZZANINE(from_mezz),
		.MEZZ_CONTROL(control), .MEZZ_BUSY(mezz_busy),
		.CMD_TO_MEZZANINE(to_mezz), .TRIGGER_WORD_BITS(word_out),
		.DET_SELECT_OUT(det_out), .SEQ_TRG_CMD(seq_trg), .SEQ_DAQ_CMD(seq_daq),
		.SEQ_TOKEN(seq_tok), .SEQ_VALID(seq_valid), .BUSY_N_O(busy_o),
		.BUSY_N_OE(busy_oe));

	tcs_mezz_model tcs_mezz_model_inst (.cmd_in(to_mezz), .sel(sel),
		.rsv_high(rsv_high), .busy_req(busy_req), .cmd_out(from_mezz),
		.control(control), .busy(mezz_busy));

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	task automatic print_verdict;
		if (mismatches == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic step;
		@(posedge clk_sys);
		#2;
	endtask

	// one full slot: strobe, mezzanine hand-over, delayed strobe, sequencer
	task automatic slot(input tcs_cmd_t live, input logic [3:0] exp_mz,
		input logic [3:0] exp_daq, input logic [11:0] exp_tok);
		logic [3:0] exp_trg;
		exp_trg = busy_req ? 4'h9 : exp_mz;
		step;
		{daq_cmd, token, trg_cmd} = live;
		word    = {live.token, live.trg_cmd};
		det_sel = {live.daq_cmd, live.trg_cmd};
		strobe  = 1'b1;
		step;
		strobe  = 1'b0;
		// change the backplane after capture so late sampling shows
		trg_cmd = ~trg_cmd;
		word    = ~word;
		step;
		step;
		`CHK("to_mezz", exp_mz, to_mezz)
		`CHK("word", {live.token, live.trg_cmd}, word_out)
		`CHK("det_sel", {live.daq_cmd, live.trg_cmd}, det_out)
		strobe_dly = 1'b1;
		step;
		// the valid pulse stands for this one cycle only
		strobe_dly = 1'b0;
		`CHK("seq_valid", 1'b1, seq_valid)
		`CHK("seq_trg", exp_trg, seq_trg)
		`CHK("seq_daq", exp_daq, seq_daq)
		`CHK("seq_tok", exp_tok, seq_tok)
		`CHK("busy_oe", {7'h00, busy_req}, busy_oe)
		`CHK("busy_o", 8'h00, busy_o)
		step;
		`CHK("seq_valid", 1'b0, seq_valid)
	endtask

	task automatic check_select_modes;
		tcs_cmd_t cur, prev;
		prev = '{4'h1, 12'h0a5, 4'h3};
		sel  = 2'd0;
		slot(prev, 4'h3, 4'h1, 12'h0a5);
		for (int s = 0; s < 4; s++) begin
			sel      = 2'(s);
			rsv_high = s[0];
			cur      = '{4'(s + 4), 12'(s * 17 + 1), 4'(s + 2)};
			if (s < 2)
				slot(cur, cur.trg_cmd, cur.daq_cmd, cur.token);
			else if (s == 2)
				slot(cur, cur.trg_cmd, prev.daq_cmd, prev.token);
			else
				slot(cur, cur.trg_cmd, 4'h0, 12'h000);
			prev = cur;
		end
		rsv_high = 1'b0;
	endtask

	// a zero command must not become the previous valid one
	task automatic check_prev_skip;
		sel = 2'd0;
		slot('{4'h2, 12'h321, 4'h6}, 4'h6, 4'h2, 12'h321);
		slot('{4'h5, 12'h007, 4'h0}, 4'h0, 4'h5, 12'h007);
		sel = 2'd2;
		slot('{4'h8, 12'h444, 4'h7}, 4'h7, 4'h2, 12'h321);
	endtask

	task automatic check_pulser_queue;
		sel      = 2'd3;
		busy_req = 1'b1;
		slot('{4'ha, 12'h111, 4'h4}, 4'h0, 4'h0, 12'h000);
		slot('{4'hb, 12'h222, 4'h5}, 4'h0, 4'h0, 12'h000);
		busy_req = 1'b0;
		sel      = 2'd0;
		slot('{4'h0, 12'h000, 4'h0}, 4'h4, 4'ha, 12'h111);
		slot('{4'h0, 12'h000, 4'h0}, 4'h5, 4'hb, 12'h222);
		slot('{4'hc, 12'h333, 4'h6}, 4'h6, 4'hc, 12'h333);
	endtask

	// a full queue raises busy on its own until the first release
	task automatic check_queue_full;
		tcs_cmd_t q;
		sel      = 2'd3;
		busy_req = 1'b1;
		for (int n = 0; n < QUEUE_DEPTH; n++) begin
			q = '{4'(n + 1), 12'(n * 3 + 5), 4'(n + 8)};
			slot(q, 4'h0, 4'h0, 12'h000);
		end
		busy_req = 1'b0;
		sel      = 2'd0;
		step;
		step;
		`CHK("full busy_oe", 8'h01, busy_oe)
		for (int n = 0; n < QUEUE_DEPTH; n++) begin
			q = '{4'(n + 1), 12'(n * 3 + 5), 4'(n + 8)};
			slot(TCS_CMD_ZERO, q.trg_cmd, q.daq_cmd, q.token);
		end
	endtask

	initial begin
		mismatches = 0;
		checked    = 0;
		{reset_n, strobe, strobe_dly, rsv_high, busy_req, sel} = '0;
		{trg_cmd, daq_cmd, token, word, det_sel} = '0;
		repeat (3) @(posedge clk_sys);
		#2;
		reset_n = 1'b1;
		step;
		`CHK("reset valid", 1'b0, seq_valid)
		`CHK("reset oe", 8'h00, busy_oe)
		check_select_modes;
		check_prev_skip;
		check_pulser_queue;
		check_queue_full;
		print_verdict;
	end

	// hang guard, far beyond the length of all scenarios
	initial begin
		#100000;
		mismatches++;
		print_verdict;
	end
endmodule // test_trigger_command_output_select

`undef CHK
`default_nettype wire
